// ### pmx_pkg.sv
// constants for the pad function multiplexer
package pmx_pkg;
	// geometry
	localparam int NP = 8;               // pads
	localparam int NF = 8;               // function selects per pad
	localparam int FW = 3;               // function select width
	localparam int AW = 6;               // wishbone byte address width
	// per-pad reset tables, pad 0 in the low bits
	localparam logic [NP*FW-1:0] FUNC_AT_RESET = 24'h000000;
	localparam logic [NP*FW-1:0] FUNC_AT_REL   = 24'h03FFFF;
	localparam logic [NP-1:0]    RX_RST        = 8'hDF;
	localparam logic [NP-1:0]    DOFF_RST      = 8'h3F;
	localparam logic [NP-1:0]    PULL_HIGH_RST = 8'h20;
	localparam logic [NP-1:0]    PULL_LOW_RST  = 8'h10;
	localparam logic [NP-1:0]    DAISY_ELIG    = 8'h7F;
	localparam logic [NP-1:0]    BOOT_MASK     = 8'h1F;
	// deselected input value, bit pad*NF+func
	localparam logic [NP*NF-1:0] DESELECTED_INPUT_VALUE = 64'h0A00_0002_0000_0802;
	// pad setup register field positions
	localparam int F_FUNC  = 0;
	localparam int F_PULL_HIGH = 4;
	localparam int F_PULL_LOW  = 5;
	localparam int F_RX    = 6;
	localparam int F_DOFF  = 7;
	localparam int F_DAISY = 8;
	// word indices: pads at 0..NP-1, bootstrap status after them
	localparam logic [3:0] IDX_BOOT = 4'h8;
	localparam logic [3:0] IDX_LAST_PAD = 4'h7;
endpackage

// ### pmx_sync2.sv
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module pmx_sync2 #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// levels
	input  wire logic [W-1:0] async,
	output logic      [W-1:0] synced
);
	logic [W-1:0] meta;

	// first stage feeds only the second; reset rests at the idle level of each pin
	always_ff @(posedge clk) begin
		if (rst) begin
			meta   <= INIT;
			synced <= INIT;
		end else begin
			meta   <= async;
			synced <= meta;
		end
	end
endmodule // pmx_sync2

// ### pmx_pad_slice.sv
// combinational routing for one pad
`timescale 1ns/1ps
module pmx_pad_slice (
	// pad setup
	input  wire logic [pmx_pkg::FW-1:0] func,
	input  wire logic                   receiverOn,
	input  wire logic                   driverOff,
	input  wire logic [pmx_pkg::NF-1:0] deselectedInputValue,
	// peripheral side
	input  wire logic [pmx_pkg::NF-1:0] perOut,
	input  wire logic [pmx_pkg::NF-1:0] perOe,
	output logic      [pmx_pkg::NF-1:0] nextPerIn,
	// pad side
	input  wire logic                   padLevel,
	output logic                        nextPadOut,
	output logic                        nextPadOeLow
);
	// output path follows the selected function only
	assign nextPadOut   = perOut[func];
	assign nextPadOeLow = driverOff | ~perOe[func];

	// pad level reaches only the selected input; the rest see their constant
	genvar f;
	generate
		for (f = 0; f < pmx_pkg::NF; f++) begin : g_in
			wire sel = (int'(func) == f) && receiverOn;
			assign nextPerIn[f] = sel ? padLevel : deselectedInputValue[f];
		end
	endgenerate
endmodule // pmx_pad_slice

// ### pmx_pad_mux.sv
// pad function multiplexer with per-pad setup registers on wishbone
// Functional notes
// - select 0 is primary; reset default separate
// - selects 1..7 route alternate functions
// - reset-out release loads per-pad release select
// - bootstrap pads latched on power/full reset rise
// - unselected peripheral inputs get fixed constants
// - receiver bit: 0 off, 1 on
// - driver-off bit: 0 drives, 1 off
// - pull-up and pull-down under software control
// - power-on reset: high impedance with listed pull
// - only eligible pads join the daisy chain
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module pmx_pad_mux (
	// clock and synchronous reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// device resets, asynchronous pins
	input  wire logic                           powerOnResetLow,
	input  wire logic                           fullResetLow,
	input  wire logic                           resetOutLow,
	// wishbone slave
	input  wire logic                           wbCyc,
	input  wire logic                           wbStb,
	input  wire logic                           wbWe,
	input  wire logic [pmx_pkg::AW-1:0]         wbAdr,
	input  wire logic [3:0]                     wbSel,
	input  wire logic [31:0]                    wbDatIn,
	output logic      [31:0]                    wbDatOut,
	output logic                                wbAck,
	// peripherals, index pad*NF+func
	input  wire logic [pmx_pkg::NP*pmx_pkg::NF-1:0] perOut,
	input  wire logic [pmx_pkg::NP*pmx_pkg::NF-1:0] perOe,
	output logic      [pmx_pkg::NP*pmx_pkg::NF-1:0] perIn,
	// pads
	input  wire logic [pmx_pkg::NP-1:0]         padIn,
	output logic      [pmx_pkg::NP-1:0]         padOut,
	output logic      [pmx_pkg::NP-1:0]         padOeLow,
	output logic      [pmx_pkg::NP-1:0]         pullHighResistor,
	output logic      [pmx_pkg::NP-1:0]         pullLowResistor,
	output logic      [pmx_pkg::NP-1:0]         daisyEn,
	// latched bootstrap straps
	output logic      [pmx_pkg::NP-1:0]         bootstrap
);
	localparam int NP = pmx_pkg::NP;
	localparam int NF = pmx_pkg::NF;
	localparam int FW = pmx_pkg::FW;
	// device reset pins idle high, pads rest low in the synchroniser during rst
	localparam logic [NP+2:0] SYNC_IDLE = {3'h7, {NP{1'h0}}};

	// synchronised pins
	logic [NP+2:0]          syncOut;
	logic [NP-1:0]          padSync;
	logic                   porSync;
	logic                   fullSync;
	logic                   rstOutSync;
	logic                   porDly;
	logic                   fullDly;
	logic                   rstOutDly;
	// pad setup storage
	logic [NP-1:0][FW-1:0]  padFunc;
	logic [NP-1:0]          pullHighEn;
	logic [NP-1:0]          pullLowEn;
	logic [NP-1:0]          receiverOn;
	logic [NP-1:0]          driverOff;
	logic [NP-1:0]          daisyCfg;
	// combinational results
	logic [NP*NF-1:0]       nextPerIn;
	logic [NP-1:0]          nextPadOut;
	logic [NP-1:0]          nextPadOeLow;

	pmx_sync2 #(.W(NP+3), .INIT(SYNC_IDLE)) u_sync (
		.clk    (clk),
		.rst    (rst),
		.async  ({resetOutLow, fullResetLow, powerOnResetLow, padIn}),
		.synced (syncOut)
	);
	assign padSync    = syncOut[NP-1:0];
	assign porSync    = syncOut[NP];
	assign fullSync   = syncOut[NP+1];
	assign rstOutSync = syncOut[NP+2];

	// reset edge detection; rests high so leaving rst never fakes a rise
	always_ff @(posedge clk) begin
		if (rst) begin
			porDly    <= 1'h1;
			fullDly   <= 1'h1;
			rstOutDly <= 1'h1;
		end else begin
			porDly    <= porSync;
			fullDly   <= fullSync;
			rstOutDly <= rstOutSync;
		end
	end

	wire porActive  = ~porSync;
	wire cfgReset   = rst | ~porSync | ~fullSync;
	wire relEdge    = rstOutSync & ~rstOutDly;
	wire bootEdge   = (porSync & ~porDly) | (fullSync & ~fullDly);

	// wishbone decode: one aligned word per register
	wire [3:0] wbIdx    = wbAdr[5:2];
	wire       wbReq    = wbCyc & wbStb;
	wire       wbFire   = wbReq & wbAck;
	wire       wbIsPad  = wbIdx <= pmx_pkg::IDX_LAST_PAD;
	wire       wbIsBoot = wbIdx == pmx_pkg::IDX_BOOT;
	wire       wbWrLo   = wbFire & wbWe & wbIsPad & wbSel[0];
	wire       wbWrHi   = wbFire & wbWe & wbIsPad & wbSel[1];
	wire [2:0] wbPad    = wbIdx[2:0];

	// read mux; unmapped words read as zero
	wire [31:0] padWord = {23'h000000,
		daisyCfg[wbPad], driverOff[wbPad], receiverOn[wbPad],
		pullLowEn[wbPad], pullHighEn[wbPad], 1'b0, padFunc[wbPad]};
	wire [31:0] bootWord = {24'h000000, bootstrap};
	wire [31:0] rdWord = wbIsPad ? padWord : (wbIsBoot ? bootWord : 32'h00000000);

	// ack one cycle after the request, dropped after one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			wbAck    <= 1'b0;
			wbDatOut <= 32'h00000000;
		end else begin
			wbAck    <= wbReq & ~wbAck;
			wbDatOut <= (wbReq & ~wbAck & ~wbWe) ? rdWord : 32'h00000000;
		end
	end

	// per-pad setup registers
	genvar p;
	generate
		for (p = 0; p < NP; p++) begin : g_pad
			wire hit   = int'(wbPad) == p;
			wire wrLo  = wbWrLo & hit;
			wire wrHi  = wbWrHi & hit;

			// release load beats a software write in the same cycle
			always_ff @(posedge clk) begin
				if (cfgReset) begin
					padFunc[p] <= pmx_pkg::FUNC_AT_RESET[p*FW +: FW];
				end else if (relEdge) begin
					padFunc[p] <= pmx_pkg::FUNC_AT_REL[p*FW +: FW];
				end else if (wrLo) begin
					padFunc[p] <= wbDatIn[pmx_pkg::F_FUNC +: FW];
				end
			end

			// electrical setup bits
			always_ff @(posedge clk) begin
				if (cfgReset) begin
					pullHighEn[p] <= pmx_pkg::PULL_HIGH_RST[p];
					pullLowEn[p]  <= pmx_pkg::PULL_LOW_RST[p];
					receiverOn[p] <= pmx_pkg::RX_RST[p];
					driverOff[p]  <= pmx_pkg::DOFF_RST[p];
				end else if (wrLo) begin
					pullHighEn[p] <= wbDatIn[pmx_pkg::F_PULL_HIGH];
					pullLowEn[p]  <= wbDatIn[pmx_pkg::F_PULL_LOW];
					receiverOn[p] <= wbDatIn[pmx_pkg::F_RX];
					driverOff[p]  <= wbDatIn[pmx_pkg::F_DOFF];
				end
			end

			// ineligible pads can never be chained
			always_ff @(posedge clk) begin
				if (cfgReset) begin
					daisyCfg[p] <= 1'b0;
				end else if (wrHi) begin
					daisyCfg[p] <= wbDatIn[pmx_pkg::F_DAISY] & pmx_pkg::DAISY_ELIG[p];
				end
			end

			pmx_pad_slice u_slice (
				.func         (padFunc[p]),
				.receiverOn   (receiverOn[p]),
				.driverOff    (driverOff[p]),
				.deselectedInputValue (pmx_pkg::DESELECTED_INPUT_VALUE[p*NF +: NF]),
				.perOut       (perOut[p*NF +: NF]),
				.perOe        (perOe[p*NF +: NF]),
				.nextPerIn    (nextPerIn[p*NF +: NF]),
				.padLevel     (padSync[p]),
				.nextPadOut   (nextPadOut[p]),
				.nextPadOeLow (nextPadOeLow[p])
			);
		end
	endgenerate

	// pad and peripheral outputs; power-on reset forces high impedance
	always_ff @(posedge clk) begin
		if (rst | porActive) begin
			padOut           <= '0;
			padOeLow         <= '1;
			pullHighResistor <= pmx_pkg::PULL_HIGH_RST;
			pullLowResistor  <= pmx_pkg::PULL_LOW_RST;
			perIn            <= pmx_pkg::DESELECTED_INPUT_VALUE;
			daisyEn          <= '0;
		end else begin
			padOut           <= nextPadOut;
			padOeLow         <= nextPadOeLow;
			pullHighResistor <= pullHighEn;
			pullLowResistor  <= pullLowEn;
			perIn            <= nextPerIn;
			daisyEn          <= daisyCfg;
		end
	end

	// straps are caught only at the rise of power-on or full reset, never remuxed
	always_ff @(posedge clk) begin
		if (rst) begin
			bootstrap <= '0;
		end else if (bootEdge) begin
			bootstrap <= padSync & pmx_pkg::BOOT_MASK;
		end
	end

	// checks, all on clk and disabled by rst
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_pad0_write;
		wbFire && wbWe && wbSel[0] && (wbIdx == 4'h0) && porSync && fullSync && !relEdge;
	endsequence

	property p_release_load;
		relEdge && !cfgReset |=> padFunc[0] == pmx_pkg::FUNC_AT_REL[FW-1:0];
	endproperty
	a_release_load: assert property (p_release_load) else $error("release value not loaded");

	property p_por_hiz;
		porActive |=> (padOeLow == '1) && (pullHighResistor == pmx_pkg::PULL_HIGH_RST);
	endproperty
	a_por_hiz: assert property (p_por_hiz) else $error("pads not released to reset state");

	property p_boot_latch;
		bootEdge |=> bootstrap == ($past(padSync) & pmx_pkg::BOOT_MASK);
	endproperty
	a_boot_latch: assert property (p_boot_latch) else $error("strap latch wrong");

	property p_rx_off;
		!porActive && !receiverOn[0] |=>
			perIn[NF-1:0] == pmx_pkg::DESELECTED_INPUT_VALUE[NF-1:0];
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("receiver off leaked pad level");

	property p_deselect;
		!porActive && padFunc[0] != 3'h1 |=> perIn[1] == pmx_pkg::DESELECTED_INPUT_VALUE[1];
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselected input not constant");

	property p_driver_off;
		!porActive && driverOff[0] |=> padOeLow[0];
	endproperty
	a_driver_off: assert property (p_driver_off) else $error("driver on while disabled");

	property p_daisy;
		(daisyEn & ~pmx_pkg::DAISY_ELIG) == '0;
	endproperty
	a_daisy: assert property (p_daisy) else $error("ineligible pad chained");

	property p_pull_write;
		s_pad0_write ##1 porSync |=>
			pullHighResistor[0] == $past(wbDatIn[pmx_pkg::F_PULL_HIGH], 2);
	endproperty
	a_pull_write: assert property (p_pull_write) else $error("pull-up write lost");

	property p_route_out;
		!porActive && padFunc[0] == 3'h2 && !driverOff[0] |=> padOut[0] == $past(perOut[2]);
	endproperty
	a_route_out: assert property (p_route_out) else $error("pad output not routed");

	property p_func_write;
		s_pad0_write |=> padFunc[0] == $past(wbDatIn[FW-1:0]);
	endproperty
	a_func_write: assert property (p_func_write) else $error("select write lost");

	property p_ack;
		wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck;
	endproperty
	a_ack: assert property (p_ack) else $error("wishbone ack timing");

	// full reset alone must still return the setup to its table values
	property p_full_cfg;
		!fullSync |=> padFunc[0] == pmx_pkg::FUNC_AT_RESET[FW-1:0] &&
			receiverOn == pmx_pkg::RX_RST && driverOff == pmx_pkg::DOFF_RST;
	endproperty
	a_full_cfg: assert property (p_full_cfg) else $error("not at reset");

	property p_rx_on;
		!porActive && receiverOn[0] && padFunc[0] == 3'h0 |=>
			perIn[0] == $past(padSync[0]);
	endproperty
	a_rx_on: assert property (p_rx_on) else $error("pad level not routed");

	property p_driver_on;
		!porActive && !driverOff[0] && padFunc[0] == 3'h0 |=>
			padOeLow[0] == !$past(perOe[0]);
	endproperty
	a_driver_on: assert property (p_driver_on) else $error("enable not routed");

	property p_boot_hold;
		!bootEdge |=> $stable(bootstrap);
	endproperty
	a_boot_hold: assert property (p_boot_hold) else $error("strap changed");

	property p_por_pins;
		porActive |=> (pullLowResistor == pmx_pkg::PULL_LOW_RST) &&
			(perIn == pmx_pkg::DESELECTED_INPUT_VALUE);
	endproperty
	a_por_pins: assert property (p_por_pins) else $error("reset pins wrong");
endmodule // pmx_pad_mux

// ### testbench.sv
// self-checking bench for the pad function multiplexer
`timescale 1ns/1ps
module testbench;
	// clock, resets and bus master
	logic clk = 1'h0, rst = 1'h1, porL = 1'h1, fullL = 1'h1, rstOutL = 1'h0;
	logic wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0;
	logic [5:0] wbAdr = 6'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDatIn = 32'h0, wbDatOut;
	logic wbAck;
	// peripheral and pad side
	logic [63:0] perOut = 64'h0, perOe = 64'h0, perIn;
	logic [7:0] padIn = 8'h00, padOut, padOeLow, pullHigh, pullLow, daisyEn, bootstrap;
	// bench model state
	logic [8:0] cfg [8];
	logic porOn = 1'h0;
	int seed = 80, nFail = 0, nTests = 0, cycles = 0;

	pmx_pad_mux i_pmx_pad_mux (.clk(clk), .rst(rst), .powerOnResetLow(porL),
		.fullResetLow(fullL), .resetOutLow(rstOutL), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
		.wbDatOut(wbDatOut), .wbAck(wbAck), .perOut(perOut), .perOe(perOe),
		.perIn(perIn), .padIn(padIn), .padOut(padOut), .padOeLow(padOeLow),
		.pullHighResistor(pullHigh), .pullLowResistor(pullLow), .daisyEn(daisyEn),
		.bootstrap(bootstrap));

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// hang guard: generous against about 650 cycles of real work
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			nFail++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// model reset: every pad back to its own table entry
	task automatic modelReset();
		for (int p = 0; p < 8; p++)
			cfg[p] = {1'h0, pmx_pkg::DOFF_RST[p], pmx_pkg::RX_RST[p],
				pmx_pkg::PULL_LOW_RST[p], pmx_pkg::PULL_HIGH_RST[p], 1'h0,
				pmx_pkg::FUNC_AT_RESET[p*3+:3]};
	endtask

	// classic single cycle; waits for ack, only the global guard ends a hang
	task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] dat,
			output logic [31:0] rd);
		@(posedge clk);
		wbCyc <= 1'h1;
		wbStb <= 1'h1;
		wbWe <= we;
		wbAdr <= adr;
		wbDatIn <= dat;
		wbSel <= 4'h3;
		do begin
			@(posedge clk);
		end while (wbAck !== 1'h1);
		rd = wbDatOut;
		wbCyc <= 1'h0;
		wbStb <= 1'h0;
		wbWe <= 1'h0;
	endtask

	task automatic writePad(input int p, input logic [8:0] v);
		logic [31:0] rd;
		v[3] = 1'h0;
		wb(1'h1, 6'(p * 4), {23'h0, v}, rd);
		v[8] = v[8] & pmx_pkg::DAISY_ELIG[p];
		cfg[p] = v;
	endtask

	task automatic readPad(input int p);
		logic [31:0] rd;
		wb(1'h0, 6'(p * 4), 32'h0, rd);
		cmp("pad setup read", {55'h0, cfg[p]}, {32'h0, rd});
	endtask

	// expected pins from the model; power-on reset forces high impedance and deselected values
	task automatic checkPins();
		logic [7:0] pO, oe, pH, pL, dz;
		logic [63:0] pi;
		int k;
		pi = pmx_pkg::DESELECTED_INPUT_VALUE;
		for (int p = 0; p < 8; p++) begin
			k = p * 8 + int'(cfg[p][2:0]);
			pH[p] = cfg[p][4];
			pL[p] = cfg[p][5];
			dz[p] = cfg[p][8];
			pO[p] = perOut[k];
			oe[p] = porOn | cfg[p][7] | ~perOe[k];
			if (!porOn && cfg[p][6])
				pi[k] = padIn[p];
		end
		cmp("pull high", {56'h0, pH}, {56'h0, pullHigh});
		cmp("pull low", {56'h0, pL}, {56'h0, pullLow});
		cmp("pad oe low", {56'h0, oe}, {56'h0, padOeLow});
		cmp("daisy", {56'h0, dz}, {56'h0, daisyEn});
		cmp("periph in", pi, perIn);
		if (!porOn)
			cmp("pad out", {56'h0, pO}, {56'h0, padOut});
	endtask

	// random peripheral and pad levels, then let the synchronisers settle
	task automatic shake();
		perOut <= {$random(seed), $random(seed)};
		perOe <= {$random(seed), $random(seed)};
		padIn <= 8'($random(seed));
		repeat (6) @(posedge clk);
	endtask

	initial begin
		logic [8:0] v;
		logic [31:0] rd;
		modelReset();
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		shake();
		checkPins();
		for (int p = 0; p < 8; p++)
			readPad(p);
		// reset-out release loads each pad's release select
		rstOutL <= 1'h1;
		repeat (6) @(posedge clk);
		for (int p = 0; p < 8; p++)
			cfg[p][2:0] = pmx_pkg::FUNC_AT_REL[p*3+:3];
		for (int p = 0; p < 8; p++)
			readPad(p);
		checkPins();
		// every select code on every pad, other fields random
		for (int r = 0; r < 16; r++) begin
			for (int p = 0; p < 8; p++) begin
				v = 9'($random(seed));
				v[2:0] = 3'((r + p) % 8);
				// each pad and select owns its own input, and every code is a defined slot
				writePad(p, v);
			end
			shake();
			checkPins();
			readPad(r % 8);
		end
		// unmapped index: acked, reads zero, write has no effect
		wb(1'h1, 6'h30, 32'hFFFF_FFFF, rd);
		wb(1'h0, 6'h30, 32'h0, rd);
		cmp("unmapped read", 64'h0, {32'h0, rd});
		checkPins();
		// power-on reset: straps latched at its release
		porL <= 1'h0;
		repeat (6) @(posedge clk);
		modelReset();
		porOn = 1'h1;
		checkPins();
		porL <= 1'h1;
		repeat (8) @(posedge clk);
		porOn = 1'h0;
		cmp("bootstrap", {56'h0, padIn & pmx_pkg::BOOT_MASK}, {56'h0, bootstrap});
		wb(1'h0, 6'h20, 32'h0, rd);
		cmp("bootstrap word", {56'h0, padIn & pmx_pkg::BOOT_MASK}, {32'h0, rd});
		checkPins();
		readPad(0);
		// full reset with other strap levels
		padIn <= padIn ^ 8'h15;
		fullL <= 1'h0;
		repeat (6) @(posedge clk);
		// full reset only restores the setup; pads keep following it
		modelReset();
		checkPins();
		fullL <= 1'h1;
		repeat (8) @(posedge clk);
		cmp("bootstrap", {56'h0, padIn & pmx_pkg::BOOT_MASK}, {56'h0, bootstrap});
		checkPins();
		wrap_up();
	end
endmodule // testbench
